/* logic/gwd_pkg.sv */
package gwd_pkg;

    // database geometry
    localparam int             DB_SIZE   = 4096;
    localparam int             DB_AW     = 12;
    localparam logic [11:0]    DB_LAST   = 12'hFFF;

    // service object table defaults
    localparam int             NOBJ_DEF  = 8;
    localparam int             MULT_W    = 16;
    localparam logic [15:0]    MULT_ONE  = 16'h0001;

    // bytes taken in the database per value width
    localparam logic [2:0]     NB_8      = 3'h1;
    localparam logic [2:0]     NB_16     = 3'h2;
    localparam logic [2:0]     NB_32     = 3'h4;

    // value width selected by a service object's data type
    typedef enum logic [1:0] {
        W8  = 2'h0,
        W16 = 2'h1,
        W32 = 2'h2
    } gwd_width_type;

    // scheduler states, one-hot
    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_ISSUE = 4'h2,
        S_STORE = 4'h4,
        S_SWEEP = 4'h8
    } gwd_state_type;

    // one configured service object
    typedef struct packed {
        logic                valid;
        logic                is_write;
        logic [DB_AW-1:0]    addr;
        gwd_width_type       width;
        logic                sgn;
        logic                flt;
        logic [MULT_W-1:0]   mult;
    } gwd_obj_type;

    // number of database bytes a width occupies
    function automatic logic [2:0] gwd_nbytes(input gwd_width_type w);
        logic [2:0] n;
        n = NB_32;
        if (w == W8)
            n = NB_8;
        else if (w == W16)
            n = NB_16;
        return n;
    endfunction

endpackage

/* logic/gwd_conv_if.sv */
`timescale 1ns/1ps
// carries one value between database bytes and network form
interface gwd_conv_if;
    import gwd_pkg::*;
    logic [31:0]         raw;        // db bytes, lane 0 = lowest address
    gwd_width_type       width;      // value width
    logic                sgn;        // signed type
    logic                flt;        // float type
    logic                big;        // big-endian ordering
    logic [MULT_W-1:0]   mult;       // integer multiplier
    logic [31:0]         net_in;     // value read from the network
    logic [31:0]         net_out;    // value to send to the network
    logic [31:0]         bytes_out;  // db bytes to store, lane 0 lowest

    modport main (output raw, width, sgn, flt, big, mult, net_in,
                  input  net_out, bytes_out);
    modport conv (input  raw, width, sgn, flt, big, mult, net_in,
                  output net_out, bytes_out);
endinterface

/* logic/gwd_conv.sv */
`timescale 1ns/1ps
// purely combinational value converter between db and network form
module gwd_conv
    import gwd_pkg::*;
(
    // conversion channel
    gwd_conv_if.conv   cv
);

    // outbound: assemble, extend, scale up
    always_comb
    begin
        logic [31:0]         val;
        logic [2:0]          nb;
        logic [MULT_W-1:0]   m;
        logic signed [48:0]  prod;
        val = 32'h0;
        nb = gwd_nbytes(cv.width);
        m = (cv.mult == 16'h0) ? MULT_ONE : cv.mult;
        for (int k = 0; k < 4; k++)
        begin
            if (k < int'(nb))
            begin
                if (cv.big)
                    val = {val[23:0], cv.raw[8*k +: 8]};
                else
                    val[8*k +: 8] = cv.raw[8*k +: 8];
            end
        end
        // 0xFF reads as 255 unsigned, -1 signed
        if (cv.sgn && nb == NB_8)
            val = {{24{val[7]}}, val[7:0]};        // R13
        else if (cv.sgn && nb == NB_16)
            val = {{16{val[15]}}, val[15:0]};      // R12
        prod = $signed({val[31] & cv.sgn, val}) * $signed({1'b0, m});
        // float values pass unscaled, the integer multiplier has no meaning
        cv.net_out = cv.flt ? val : prod[31:0];    // R11
    end

    // inbound: scale down, truncate to width, split into bytes
    always_comb
    begin
        logic [31:0]         q;
        logic [31:0]         sh;
        logic [2:0]          nb;
        logic [MULT_W-1:0]   m;
        q = 32'h0;
        sh = 32'h0;
        nb = gwd_nbytes(cv.width);
        m = (cv.mult == 16'h0) ? MULT_ONE : cv.mult;
        if (cv.flt)
            q = cv.net_in;
        else if (cv.sgn)
            q = $signed(cv.net_in) / $signed({16'h0, m});   // R09
        else
            q = cv.net_in / {16'h0, m};                     // R09
        cv.bytes_out = 32'h0;
        // bytes above the width are simply dropped, so values wrap
        for (int k = 0; k < 4; k++)
        begin
            if (k < int'(nb))
            begin
                if (cv.big)
                    sh = q >> (8 * (int'(nb) - 1 - k));     // R02
                else
                    sh = q >> (8 * k);                      // R03
                cv.bytes_out[8*k +: 8] = sh[7:0];           // R14
            end
        end
    end

endmodule

/* logic/gwd_core.sv */
`timescale 1ns/1ps
// Overview of operation
// R01: byte-addressable 4096-byte shared database
// R02: big-endian puts most significant byte lowest
// R03: little-endian puts least significant byte lowest
// R04: each service object is read or write
// R05: reads issued in round-robin object order
// R06: pending writes go before any read
// R07: reads resume after last issued read
// R08: other network served from local copies
// R09: read value divided by multiplier before storing
// R10: changed write-object bytes trigger remote write
// R11: outbound value is database value times multiplier
// R12: data type sets width, sign, integer or float
// R13: 0xFF is 255 unsigned, -1 signed
// R14: oversized values wrap to the type width
// R15: link loss loads per-address fail-safe values; a loss that starts in S_STORE starts no sweep
module gwd_core
    import gwd_pkg::*;
#(
    parameter int NOBJ = NOBJ_DEF,
    parameter int IW   = $clog2(NOBJ)
)
(
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    // service object configuration
    input  wire logic              CFG_WE,
    input  wire logic [IW-1:0]     CFG_INDEX,
    input  wire logic              CFG_VALID,
    input  wire logic              CFG_IS_WRITE,
    input  wire logic [DB_AW-1:0]  CFG_ADDR,
    input  wire logic [1:0]        CFG_WIDTH,
    input  wire logic              CFG_SIGNED,
    input  wire logic              CFG_FLOAT,
    input  wire logic [MULT_W-1:0] CFG_MULT,
    input  wire logic              BIG_ENDIAN,
    // fail-safe table
    input  wire logic              FS_WE,
    input  wire logic [DB_AW-1:0]  FS_ADDR,
    input  wire logic [7:0]        FS_DATA,
    input  wire logic              FS_ENABLE,
    input  wire logic              LINK_LOST,
    output logic                   FAILSAFE_ACTIVE,
    // local database access from the other network
    input  wire logic              LOC_REQ,
    input  wire logic              LOC_WE,
    input  wire logic [DB_AW-1:0]  LOC_ADDR,
    input  wire logic [7:0]        LOC_WDATA,
    output logic                   LOC_ACK,
    output logic [7:0]             LOC_RDATA,
    // requests to remote devices
    output logic                   NET_REQ,
    output logic                   NET_IS_WRITE,
    output logic [IW-1:0]          NET_INDEX,
    output logic [31:0]            NET_VALUE,
    input  wire logic              NET_DONE,
    input  wire logic [31:0]       NET_RDATA
);

    // all control state of the block
    typedef struct packed {
        gwd_state_type            st;        // scheduler state
        gwd_obj_type [NOBJ-1:0]   obj;       // service object table
        logic [NOBJ-1:0]          pend;      // writes waiting to go out
        logic [IW-1:0]            cur;       // object in flight
        logic [IW-1:0]            rr_last;   // last read issued
        logic                     cur_wr;    // object in flight is a write
        logic [31:0]              rd;        // value returned by a read
        logic                     net_req;   // request to the network
        logic                     net_wr;    // request is a write
        logic [31:0]              net_val;   // outbound value
        logic                     loc_ack;   // local access answered
        logic [7:0]               loc_rdata; // local read data
        logic [DB_AW-1:0]         swp;       // fail-safe sweep address
        logic                     link_q;    // link-lost seen last cycle
        logic                     fs_act;    // sweep running
    } gwd_core_type;

    gwd_core_type  q;   // registered state
    gwd_core_type  d;   // next state

    logic [7:0]  db     [DB_SIZE];   // shared database, R01
    logic [7:0]  fs_val [DB_SIZE];   // fail-safe value per address
    logic        fs_en  [DB_SIZE];   // address takes its fail-safe value

    logic [3:0]             lane_we;    // byte lanes written this cycle
    logic [3:0][DB_AW-1:0]  lane_a;     // lane addresses
    logic [3:0][7:0]        lane_d;     // lane data
    logic                   wr_found;   // some write is pending
    logic [IW-1:0]          wr_idx;     // lowest pending write
    logic                   rd_found;   // some read object exists
    logic [IW-1:0]          rd_idx;     // next read in rotation
    logic [IW-1:0]          sel;        // object fed to the converter
    logic [NOBJ-1:0]        hit;        // write objects whose bytes changed
    gwd_obj_type            so;         // selected object

    gwd_conv_if cv ();

    gwd_conv u_conv (
        .cv (cv)
    );

    // pick the next candidate objects
    always_comb
    begin
        int t;
        wr_found = 1'b0;
        wr_idx = '0;
        rd_found = 1'b0;
        rd_idx = '0;
        t = 0;
        for (int k = NOBJ - 1; k >= 0; k--)
        begin
            if (q.pend[k])
            begin
                wr_found = 1'b1;       // R06
                wr_idx = IW'(k);
            end
        end
        // walk forward from the last read; the nearest one wins
        for (int j = NOBJ; j >= 1; j--)
        begin
            t = int'(q.rr_last) + j;
            if (t >= NOBJ)
                t = t - NOBJ;
            if (q.obj[t].valid && !q.obj[t].is_write)
            begin
                rd_found = 1'b1;       // R05
                rd_idx = IW'(t);       // R07
            end
        end
        // in idle the converter prepares the write about to be issued
        if (q.st == S_IDLE)
            sel = wr_found ? wr_idx : rd_idx;
        else
            sel = q.cur;
        so = q.obj[sel];
    end

    // converter inputs from the selected object's database bytes
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            cv.raw[8*k +: 8] = db[so.addr + DB_AW'(k)];
        cv.width = so.width;             // R12
        cv.sgn = so.sgn;
        cv.flt = so.flt;
        cv.big = BIG_ENDIAN;
        cv.mult = so.mult;
        cv.net_in = q.rd;
    end

    // next-state logic
    always_comb
    begin
        logic loc_take;
        logic sweep_go;
        logic [2:0] nb;
        logic [DB_AW-1:0] off;
        d = q;
        d.loc_ack = 1'b0;
        d.link_q = LINK_LOST;
        lane_we = '0;
        lane_a = '0;
        lane_d = '0;
        hit = '0;
        nb = gwd_nbytes(so.width);
        off = '0;
        sweep_go = LINK_LOST && !q.link_q;
        // local access waits out the store and sweep states
        loc_take = LOC_REQ && !q.loc_ack && !sweep_go
                   && (q.st == S_IDLE || q.st == S_ISSUE);
        if (CFG_WE)
        begin
            d.obj[CFG_INDEX].valid = CFG_VALID;
            d.obj[CFG_INDEX].is_write = CFG_IS_WRITE;     // R04
            d.obj[CFG_INDEX].addr = CFG_ADDR;
            d.obj[CFG_INDEX].width = gwd_width_type'(CFG_WIDTH);
            d.obj[CFG_INDEX].sgn = CFG_SIGNED;
            d.obj[CFG_INDEX].flt = CFG_FLOAT;
            d.obj[CFG_INDEX].mult = CFG_MULT;
        end
        // answered from the mirrored copy, no network traffic
        if (loc_take)
        begin
            d.loc_ack = 1'b1;                              // R08
            d.loc_rdata = db[LOC_ADDR];
            lane_we[0] = LOC_WE;
            lane_a[0] = LOC_ADDR;
            lane_d[0] = LOC_WDATA;
        end
        unique case (q.st)
            S_IDLE:
            begin
                if (sweep_go)
                begin
                    d.st = S_SWEEP;
                    d.swp = '0;
                    d.fs_act = 1'b1;
                end
                else if (wr_found)
                begin
                    d.cur = wr_idx;                        // R06
                    d.cur_wr = 1'b1;
                    d.net_req = 1'b1;
                    d.net_wr = 1'b1;
                    d.net_val = cv.net_out;                // R11
                    d.st = S_ISSUE;
                end
                else if (rd_found)
                begin
                    d.cur = rd_idx;                        // R05
                    d.rr_last = rd_idx;                    // R07
                    d.cur_wr = 1'b0;
                    d.net_req = 1'b1;
                    d.net_wr = 1'b0;
                    d.net_val = 32'h0;
                    d.st = S_ISSUE;
                end
            end
            S_ISSUE:
            begin
                // a lost link abandons the request; a write stays pending
                if (sweep_go)
                begin
                    d.net_req = 1'b0;
                    d.st = S_SWEEP;
                    d.swp = '0;
                    d.fs_act = 1'b1;
                end
                else if (NET_DONE)
                begin
                    d.net_req = 1'b0;
                    if (q.cur_wr)
                    begin
                        d.pend[q.cur] = 1'b0;
                        d.st = S_IDLE;
                    end
                    else
                    begin
                        d.rd = NET_RDATA;
                        d.st = S_STORE;
                    end
                end
            end
            S_STORE:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    lane_we[k] = (k < int'(nb));           // R09
                    lane_a[k] = so.addr + DB_AW'(k);
                    lane_d[k] = cv.bytes_out[8*k +: 8];
                end
                d.st = S_IDLE;
            end
            S_SWEEP:
            begin
                lane_we[0] = fs_en[q.swp];                 // R15
                lane_a[0] = q.swp;
                lane_d[0] = fs_val[q.swp];
                d.swp = q.swp + 12'h001;
                if (q.swp == DB_LAST)
                begin
                    d.st = S_IDLE;
                    d.fs_act = 1'b0;
                end
            end
        endcase
        // any changed byte inside a write object's span marks it pending
        for (int l = 0; l < 4; l++)
        begin
            for (int o = 0; o < NOBJ; o++)
            begin
                off = lane_a[l] - q.obj[o].addr;
                if (lane_we[l] && db[lane_a[l]] != lane_d[l]
                    && q.obj[o].valid && q.obj[o].is_write
                    && {9'h0, off[2:0]} == off
                    && off[2:0] < gwd_nbytes(q.obj[o].width))
                    hit[o] = 1'b1;                         // R10
            end
        end
        // a change in the clearing cycle keeps the write pending
        d.pend = d.pend | hit;
    end

    // state register
    always_ff @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            q <= '0;
            q.st <= S_IDLE;
            q.rr_last <= IW'(NOBJ - 1);    // read rotation starts at object 0; first read goes to the lowest-index read object
        end
        else
            q <= d;
    end

    // database byte lanes; contents are not cleared by reset
    always_ff @(posedge CLOCK)
    begin
        for (int k = 0; k < 4; k++)
            if (lane_we[k])
                db[lane_a[k]] <= lane_d[k];                // R01
    end

    // fail-safe table load
    always_ff @(posedge CLOCK)
    begin
        if (FS_WE)
        begin
            fs_val[FS_ADDR] <= FS_DATA;
            fs_en[FS_ADDR] <= FS_ENABLE;
        end
    end

    // outputs straight from the state register
    assign FAILSAFE_ACTIVE = q.fs_act;
    assign LOC_ACK = q.loc_ack;
    assign LOC_RDATA = q.loc_rdata;
    assign NET_REQ = q.net_req;
    assign NET_IS_WRITE = q.net_wr;
    assign NET_INDEX = q.cur;
    assign NET_VALUE = q.net_val;

endmodule

/* verification/gwd_core_asserts.sv */
`timescale 1ns/1ps
// port-level watch on the core: handshakes and the fail-safe sweep
module gwd_core_asserts
    import gwd_pkg::*;
#(
    parameter int NOBJ = NOBJ_DEF,
    parameter int IW   = $clog2(NOBJ)
)
(
    // clock and reset
    input wire logic          CLOCK,
    input wire logic          RESETN,
    // local access
    input wire logic          LOC_REQ,
    input wire logic          LOC_ACK,
    // fail-safe
    input wire logic          LINK_LOST,
    input wire logic          FAILSAFE_ACTIVE,
    // network requests
    input wire logic          NET_REQ,
    input wire logic          NET_IS_WRITE,
    input wire logic [IW-1:0] NET_INDEX,
    input wire logic [31:0]   NET_VALUE,
    input wire logic          NET_DONE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    logic [12:0] fs_cnt_q; // cycles of the current sweep so far
    logic [12:0] fs_cnt_d; // next count
    // 13 bits hold a full pass plus one spare cycle
    always_comb fs_cnt_d = FAILSAFE_ACTIVE ? fs_cnt_q + 13'h0001 : 13'h0000;
    // cleared by reset so a sweep cut short does not carry over
    always_ff @(posedge CLOCK) fs_cnt_q <= RESETN ? fs_cnt_d : 13'h0000;

    // a request still open and not aborted by a fresh link loss
    sequence s_net_open;
        NET_REQ && !NET_DONE && !(LINK_LOST && !$past(LINK_LOST));
    endsequence
    // the same request, unchanged
    sequence s_net_held;
        NET_REQ && $stable(NET_INDEX) && $stable(NET_IS_WRITE)
            && $stable(NET_VALUE);
    endsequence

    a_ack_pulse: assert property (LOC_ACK |=> !LOC_ACK)
        else $error("local ack longer than one cycle");
    a_ack_cause: assert property (LOC_ACK |-> $past(LOC_REQ))
        else $error("local ack without request");
    a_req_held: assert property (s_net_open |=> s_net_held)
        else $error("network request changed before done");
    a_req_done: assert property (NET_REQ && NET_DONE |=> !NET_REQ)
        else $error("network request kept after done");
    a_lost_abort: assert property
        (NET_REQ && LINK_LOST && !$past(LINK_LOST) |=> !NET_REQ)
        else $error("request not aborted on link loss");
    a_fs_start: assert property ($rose(FAILSAFE_ACTIVE)
        |-> $past(LINK_LOST) && !$past(LINK_LOST, 2))
        else $error("sweep started without link loss edge");
    a_fs_quiet: assert property (FAILSAFE_ACTIVE |-> !NET_REQ)
        else $error("network request during sweep");
    a_fs_no_ack: assert property
        (FAILSAFE_ACTIVE && $past(FAILSAFE_ACTIVE) |-> !LOC_ACK)
        else $error("local ack during sweep");
    a_fs_length: assert property ($fell(FAILSAFE_ACTIVE)
        |-> fs_cnt_q >= 13'h1000 && fs_cnt_q <= 13'h1001)
        else $error("sweep did not cover the database once");
endmodule

bind gwd_core gwd_core_asserts #(.NOBJ(NOBJ), .IW(IW)) u_asserts (
    .CLOCK(CLOCK), .RESETN(RESETN), .LOC_REQ(LOC_REQ), .LOC_ACK(LOC_ACK),
    .LINK_LOST(LINK_LOST), .FAILSAFE_ACTIVE(FAILSAFE_ACTIVE),
    .NET_REQ(NET_REQ), .NET_IS_WRITE(NET_IS_WRITE),
    .NET_INDEX(NET_INDEX), .NET_VALUE(NET_VALUE), .NET_DONE(NET_DONE)
);

/* verification/gwd_net_model.sv */
`timescale 1ns/1ps
// remote devices: each request answered after a short or long wait
module gwd_net_model
#(
    parameter int IW = 3
)
(
    // clock and reset
    input wire logic          clock,
    input wire logic          resetn,
    // request from the core
    input wire logic          net_req,
    input wire logic [IW-1:0] net_index,
    // answer to the core
    output logic              net_done  = 1'b0,
    output logic [31:0]       net_rdata = 32'h5A5A_A5A5
);
    logic [2:0] wait_q = 3'h0; // cycles spent on this request

    // odd objects answer slowly so local traffic can overlap them;
    // off the answer cycle the data toggles, so stale data never matches
    always @(posedge clock)
    begin
        net_done  <= 1'b0;
        net_rdata <= ~net_rdata;
        if (!resetn || !net_req || net_done)
            wait_q <= 3'h0;
        else if (wait_q == (net_index[0] ? 3'h6 : 3'h1))
        begin
            net_done  <= 1'b1;
            net_rdata <= 32'h0000_0101 + 32'h0000_0111 * 32'(net_index);
            wait_q    <= 3'h0;
        end
        else
            wait_q <= wait_q + 3'h1;
    end
endmodule

/* verification/gwd_core_tb_top.sv */
`timescale 1ns/1ps
// drives the core, logs network traffic, compares with a reference
module gwd_core_tb_top
    import gwd_pkg::*;
;
    logic        clk = 1'b0, rstn = 1'b0, cfg_we = 1'b0, cfg_wr = 1'b0;
    logic        cfg_sg = 1'b0, big = 1'b1, fs_we = 1'b0, fs_en = 1'b0;
    logic        lost = 1'b0, loc_req = 1'b0, loc_we = 1'b0, loc_ack;
    logic        fs_act, net_req, net_wr, net_done;
    logic [2:0]  cfg_idx = 3'h0, net_idx;
    logic [1:0]  cfg_w = 2'h0;
    logic [11:0] cfg_a = 12'h000, fs_a = 12'h000, loc_a = 12'h000;
    logic [15:0] cfg_m = 16'h0001;
    logic [7:0]  fs_d = 8'h00, loc_d = 8'h00, loc_q, rd;
    logic [31:0] net_val, net_rd;
    int          fails = 0, checks = 0, last_rd = 0;
    int          q_idx[$];    // index of each finished request
    logic        q_wr[$];     // kind of each finished request
    logic [31:0] q_val[$];    // value sent with each request

    gwd_core #(.NOBJ(8), .IW(3)) DUT (
        .CLOCK(clk), .RESETN(rstn), .CFG_WE(cfg_we), .CFG_INDEX(cfg_idx),
        .CFG_VALID(1'b1), .CFG_IS_WRITE(cfg_wr), .CFG_ADDR(cfg_a),
        .CFG_WIDTH(cfg_w), .CFG_SIGNED(cfg_sg), .CFG_FLOAT(&cfg_w),
        .CFG_MULT(cfg_m), .BIG_ENDIAN(big), .FS_WE(fs_we), .FS_ADDR(fs_a),
        .FS_DATA(fs_d), .FS_ENABLE(fs_en), .LINK_LOST(lost),
        .FAILSAFE_ACTIVE(fs_act), .LOC_REQ(loc_req), .LOC_WE(loc_we),
        .LOC_ADDR(loc_a), .LOC_WDATA(loc_d), .LOC_ACK(loc_ack),
        .LOC_RDATA(loc_q), .NET_REQ(net_req), .NET_IS_WRITE(net_wr),
        .NET_INDEX(net_idx), .NET_VALUE(net_val), .NET_DONE(net_done),
        .NET_RDATA(net_rd));

    gwd_net_model #(.IW(3)) u_net (.clock(clk), .resetn(rstn),
        .net_req(net_req), .net_index(net_idx), .net_done(net_done),
        .net_rdata(net_rd));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // shared compare; x or z never passes
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // single place the run ends
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one local byte access, held until acknowledged; old byte in rd
    task automatic loc(input logic we, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        loc_req <= 1'b1;
        loc_we <= we;
        loc_a <= a;
        loc_d <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (loc_ack !== 1'b1 && n < 9000);
        rd = loc_q;
        if (loc_ack !== 1'b1)
        begin
            $display("ERROR local ack never came");
            fails++;
            end_sim();
        end
        loc_req <= 1'b0;
        @(posedge clk);
    endtask

    // bounded wait until the log holds cnt requests
    task automatic wait_log(input int cnt);
        int n;
        n = 0;
        while (q_idx.size() < cnt && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        if (q_idx.size() < cnt)
        begin
            $display("ERROR request log expected %0d seen %0d", cnt,
                     q_idx.size());
            fails++;
            end_sim();
        end
    endtask

    // holds cfg_we high across a burst; caller lowers it afterwards
    task automatic cfg(input logic [2:0] i, input logic wr,
                       input logic [11:0] a, input logic [1:0] w,
                       input logic s, input logic [15:0] m);
        cfg_we <= 1'b1;
        cfg_idx <= i;
        cfg_wr <= wr;
        cfg_a <= a;
        cfg_w <= w;
        cfg_sg <= s;
        cfg_m <= m;
        @(posedge clk);
    endtask

    // reference scheduler: read objects 1, 3, 0 cycle in index order
    always @(posedge clk)
        if (rstn && net_req === 1'b1 && net_done === 1'b1)
        begin
            q_idx.push_back(int'(net_idx));
            q_wr.push_back(net_wr);
            q_val.push_back(net_val);
            if (net_wr === 1'b0)
            begin
                chk("read index", last_rd == 0 ? 1 : last_rd == 1 ? 3 : 0,
                    32'(net_idx));
                last_rd = int'(net_idx);
            end
        end

    initial
    begin
        int          i, n, hi;
        logic [11:0] a, ad[8];
        logic [7:0]  d, dd[8];
        logic [11:0] ta[6] = '{12'h040, 12'h041, 12'h042, 12'h043,
                               12'h010, 12'h011};
        logic [7:0]  tv[6] = '{8'h34, 8'h04, 8'h00, 8'h00, 8'h80, 8'h00};
        void'($urandom(33653));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // fail-safe table: one enabled entry at a random address
        a = 12'h050 + 12'($urandom % 3000);
        d = 8'($urandom);
        for (i = 0; i < DB_SIZE; i++)
        begin
            fs_we <= 1'b1;
            fs_a <= 12'(i);
            fs_d <= d;
            fs_en <= (12'(i) == a);
            @(posedge clk);
        end
        fs_we <= 1'b0;
        loc(1'b1, a, ~d);
        lost <= 1'b1;
        n = 0;
        hi = 0;
        // wait for the sweep to rise and fall again
        while (n < 5000 && (hi == 0 || fs_act === 1'b1))
        begin
            @(posedge clk);
            n++;
            hi += (fs_act === 1'b1);
        end
        lost <= 1'b0;
        chk("sweep cycles", 1, hi >= 4096 && hi <= 4097);
        loc(1'b0, a, 8'h00);
        chk("fail-safe byte", d, rd);
        $display("test fail_safe done");
        // random bytes spread over the whole space, last address too
        for (i = 0; i < 8; i++)
        begin
            ad[i] = i == 7 ? DB_LAST : 12'(i * 512) + 12'($urandom % 512);
            dd[i] = 8'($urandom);
            loc(1'b1, ad[i], dd[i]);
        end
        for (i = 0; i < 8; i++)
        begin
            loc(1'b0, ad[i], 8'h00);
            chk("db byte", dd[i], rd);
        end
        $display("test byte_access done");
        // objects: write object first so reads start with object 1
        loc(1'b1, 12'h030, 8'h00);
        cfg(3'h2, 1'b1, 12'h030, 2'h0, 1'b1, 16'h0003);
        cfg(3'h1, 1'b0, 12'h020, 2'h0, 1'b0, 16'h0001);
        cfg(3'h3, 1'b0, 12'h040, 2'h3, 1'b1, 16'h0005);
        cfg(3'h0, 1'b0, 12'h010, 2'h1, 1'b0, 16'h0002);
        cfg_we <= 1'b0;
        wait_log(6);
        loc(1'b0, 12'h010, 8'h00);
        chk("obj0 high byte", 8'h00, rd);
        loc(1'b0, 12'h011, 8'h00);
        chk("obj0 low byte", 8'h80, rd);
        loc(1'b0, 12'h020, 8'h00);
        chk("obj1 wrapped", 8'h12, rd);
        $display("test read_store done");
        // change the write object's byte while slow read 1 is open
        n = 0;
        while (n < 200 && !(net_req === 1'b1 && net_idx === 3'h1
                            && net_done !== 1'b1))
        begin
            @(posedge clk);
            n++;
        end
        chk("read 1 seen", 1, n < 200);
        n = q_idx.size();
        loc(1'b1, 12'h030, 8'hFF);
        wait_log(n + 3);
        chk("open read", 1, q_idx[n]);
        chk("write first", 2, q_idx[n + 1]);
        chk("write kind", 1'b1, q_wr[n + 1]);
        chk("write value", 32'hFFFF_FFFD, q_val[n + 1]);
        chk("read resume", 3, q_idx[n + 2]);
        $display("test write_first done");
        // little-endian ordering for the following stores
        big <= 1'b0;
        wait_log(q_idx.size() + 6);
        for (i = 0; i < 6; i++)
        begin
            loc(1'b0, ta[i], 8'h00);
            chk("little byte", tv[i], rd);
        end
        $display("test little_endian done");
        end_sim();
    end
endmodule
